// file: timer_pulse_capture_compare_test.sv
// Self-checking bench for the pulse capture / compare block.
// Assumes tpcc_pkg, the checker and the pulse source are compiled first.
`timescale 1ns/1ps

module timer_pulse_capture_compare_test;
  import tpcc_pkg::*;
  typedef struct packed {
    logic wr;
    logic [15:0] idx;
    logic [7:0] d;
  } tpcc_row_t;

  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [17:0] address = 18'h00000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] writedata = 32'h00000000;
  logic [7:0] a_cnt = 8'h00;
  tpcc_pins_t y_pin = 2'b00;
  tpcc_pins_t b_pin = 2'b00;
  logic [31:0] readdata;
  logic waitrequest, x_in, a_in, cmp_c, irq;
  tpcc_pins_t y_ext, b_ext;
  logic [7:0] rq;
  int miscompares = 0;
  int cmp_count = 0;
  int n, hits;
  // Reads carry the expected value in d
  tpcc_row_t rows [0:26] = '{
    '{1'b0, 16'hfff5, 8'hff}, '{1'b0, 16'hfff2, 8'h00}, '{1'b0, 16'hfff3, 8'h00},
    '{1'b1, 16'hfff2, 8'h55}, '{1'b0, 16'hfff2, 8'h00}, '{1'b1, 16'hfff5, 8'ha5},
    '{1'b0, 16'hfff5, 8'ha5}, '{1'b0, 16'hffe0, 8'h00}, '{1'b1, 16'hffe0, 8'h0f},
    '{1'b0, 16'hffe0, 8'h0f}, '{1'b1, 16'hffe0, 8'h00}, '{1'b0, 16'hffe1, 8'h00},
    '{1'b0, 16'hffe3, 8'h00}, '{1'b0, 16'hffe4, 8'h00}, '{1'b1, 16'hffe1, 8'h80},
    '{1'b0, 16'hfff5, 8'hfe}, '{1'b1, 16'hfff5, 8'hff}, '{1'b0, 16'hfff5, 8'hff},
    '{1'b1, 16'hfff5, 8'h00}, '{1'b0, 16'hfff5, 8'hfe}, '{1'b0, 16'hfff2, 8'hff},
    '{1'b1, 16'hfff6, 8'h12}, '{1'b0, 16'hfff6, 8'h00}, '{1'b1, 16'hffe1, 8'h00},
    '{1'b0, 16'hfff5, 8'ha5}, '{1'b0, 16'hffe5, 8'hfe}, '{1'b0, 16'hff00, 8'h00}};

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  tpcc_top dut_u (.CORE_CLK(core_clk), .RESET(reset), .ADDRESS(address), .READ(read),
    .WRITE(write), .BYTEENABLE(byteenable), .WRITEDATA(writedata), .READDATA(readdata),
    .WAITREQUEST(waitrequest), .UNIT_X_RESET_INPUT(x_in), .UNIT_A_RESET_INPUT(a_in),
    .UNIT_A_COUNTER(a_cnt), .Y_PIN(y_pin), .B_PIN(b_pin), .Y_EXT(y_ext), .B_EXT(b_ext),
    .COMPARE_MATCH_C(cmp_c), .IRQ(irq));
  tpcc_pulse_src src_u (.clk(core_clk), .pin_x(x_in), .pin_a(a_in));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One request, held until wait drops; a fresh edge first so no signal is set twice
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] d);
    int k;
    @(posedge core_clk);
    address <= {idx, 2'b00};
    writedata <= {24'h000000, d};
    byteenable <= 4'h1;
    write <= wr;
    read <= ~wr;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    rq = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
    check("bus wait", {7'h00, waitrequest}, 8'h00);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [15:0] idx);
    bus(1'b0, idx, 8'h00);
  endtask

  task print_verdict;
    if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].idx, rows[i].d);
      if (!rows[i].wr) check($sformatf("row %0d", i), rq, rows[i].d);
    end
    y_pin <= 2'b11;
    b_pin <= 2'b10;
    repeat (2) @(posedge core_clk);
    check("y gated", {6'h00, y_ext}, 8'h00);
    check("b gated", {6'h00, b_ext}, 8'h00);
    wr(16'hffe1, 8'h80);
    wr(16'hfff5, 8'h01);
    wr(16'hffe5, 8'h01);
    wr(16'hffe1, 8'h00);
    repeat (2) @(posedge core_clk);
    check("y passed", {6'h00, y_ext}, 8'h03);
    check("b passed", {6'h00, b_ext}, 8'h02);
    // One rising edge on the passed unit two clock steps its counter once
    wr(16'hffe1, 8'h80);
    rd(16'hfff4);
    check("y count", rq, 8'h01);
    wr(16'hffe1, 8'h00);
    src_u.pulse(1'b0, 5);
    rd(16'hfff2);
    check("unarmed rise", rq, 8'h00);
    // A write of 1 without a prior read of 0 must not arm
    wr(16'hffe0, 8'h10);
    rd(16'hffe0);
    check("start refused", rq, 8'h00);
    wr(16'hffe0, 8'h10);
    rd(16'hffe0);
    check("start armed", rq, 8'h10);
    wr(16'hfff4, 8'h40);
    src_u.pulse(1'b0, 16);
    rd(16'hffe0);
    check("start cleared", rq, 8'h00);
    rd(16'hfff2);
    check("rise value", rq, 8'h41);
    rd(16'hfff3);
    check("fall value", rq, 8'h51);
    rd(16'hfff1);
    check("flag set", rq, 8'h10);
    check("irq masked", {7'h00, irq}, 8'h00);
    wr(16'hffe7, 8'h01);
    repeat (2) @(posedge core_clk);
    check("irq raised", {7'h00, irq}, 8'h01);
    rd(16'hffe6);
    check("status x", rq & 8'h03, 8'h01);
    repeat (2) @(posedge core_clk);
    check("irq cleared", {7'h00, irq}, 8'h00);
    wr(16'hfff1, 8'h00);
    rd(16'hfff1);
    check("flag cleared", rq, 8'h00);
    src_u.pulse(1'b0, 4);
    rd(16'hfff2);
    check("single shot", rq, 8'h41);
    rd(16'hffe2);
    wr(16'hffe2, 8'h08);
    a_cnt <= 8'h3c;
    fork
      src_u.pulse(1'b1, 8);
      begin
        repeat (3) @(posedge core_clk);
        a_cnt <= 8'h7e;
      end
    join
    rd(16'hffe2);
    check("a start cleared", rq, 8'h00);
    rd(16'hffe3);
    check("a rise", rq, 8'h3c);
    rd(16'hffe4);
    check("a fall", rq, 8'h7e);
    // Sum f0 + 41 wraps to 31; counter 27 reaches it ten cycles on
    wr(16'hfff5, 8'hf0);
    wr(16'hfff4, 8'h27);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!(cmp_c === 1'b1 && n > 1) && n < 300);
    check("match delay", 8'(n), 8'h0c);
    // Old sum equals the counter only in the constant's write cycle
    wr(16'hfff4, 8'h2f);
    wr(16'hfff5, 8'h00);
    hits = 0;
    repeat (6) begin
      @(posedge core_clk);
      if (cmp_c !== 1'b0) hits++;
    end
    check("suppressed", 8'(hits), 8'h00);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd(16'hfff5);
    check("sum after reset", rq, 8'hff);
    rd(16'hfff2);
    check("rise after reset", rq, 8'h00);
    rd(16'hffe0);
    check("conn after reset", rq, 8'h00);
    print_verdict();
  end
endmodule

bind tpcc_top tpcc_sva chk_u (.CORE_CLK(CORE_CLK), .RESET(RESET), .READ(READ),
  .WRITE(WRITE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .Y_PIN(Y_PIN),
  .B_PIN(B_PIN), .Y_EXT(Y_EXT), .B_EXT(B_EXT), .COMPARE_MATCH_C(COMPARE_MATCH_C), .IRQ(IRQ));

// file: tpcc_params.svh
// Constants for the timer pulse capture / compare block: offsets, bits, resets.
// Included by the package only; holds definitions, no logic.
`ifndef TPCC_PARAMS_SVH
`define TPCC_PARAMS_SVH

// Register indices; byte address is four times the index
`define TPCC_IX_W0 16'hfff0
`define TPCC_IX_W1 16'hfff1
`define TPCC_IX_W2 16'hfff2
`define TPCC_IX_W3 16'hfff3
`define TPCC_IX_W4 16'hfff4
`define TPCC_IX_W5 16'hfff5
`define TPCC_IX_W6 16'hfff6
`define TPCC_IX_W7 16'hfff7
`define TPCC_IX_CONN 16'hffe0
`define TPCC_IX_WSEL 16'hffe1
`define TPCC_IX_ABCTL 16'hffe2
`define TPCC_IX_A_RISE 16'hffe3
`define TPCC_IX_A_FALL 16'hffe4
`define TPCC_IX_B_ISEL 16'hffe5
`define TPCC_IX_IRQ_ST 16'hffe6
`define TPCC_IX_IRQ_MASK 16'hffe7

// Field positions
`define TPCC_CAPTURE_START_BIT_X_BIT 4
`define TPCC_CAPTURE_START_BIT_A_BIT 3
`define TPCC_CAPF_BIT 4
`define TPCC_WSEL_BIT 7
`define TPCC_GATE_BIT 0
`define TPCC_EV_CAPX 0
`define TPCC_EV_CAPA 1
`define TPCC_EV_CMPC 2
`define TPCC_EV_W 3

// Reset values
`define TPCC_SUMC_RST 8'hff
`define TPCC_ISEL_RST 8'hfe
`define TPCC_ZERO8 8'h00
`define TPCC_ONE8 8'h01
`define TPCC_XST_RW_MASK 8'h0f

`endif

// file: tpcc_pkg.sv
// Types for the timer pulse capture / compare block.
// Assumes tpcc_params.svh is on the include path.
`include "tpcc_params.svh"

package tpcc_pkg;

  typedef enum logic [4:0] {
    TPCC_R_NONE, TPCC_R_XCTL, TPCC_R_XST, TPCC_R_RISE, TPCC_R_FALL, TPCC_R_XCNT,
    TPCC_R_SUMC, TPCC_R_XCA, TPCC_R_XCB, TPCC_R_YCTL, TPCC_R_YST, TPCC_R_YCA,
    TPCC_R_YCB, TPCC_R_YCNT, TPCC_R_YISEL, TPCC_R_CONN, TPCC_R_WSEL, TPCC_R_ABCTL,
    TPCC_R_ARISE, TPCC_R_AFALL, TPCC_R_BISEL, TPCC_R_IST, TPCC_R_IMSK
  } tpcc_reg_t;

  typedef enum logic [2:0] {
    TPCC_CAP_IDLE = 3'b001,
    TPCC_CAP_RISE = 3'b010,
    TPCC_CAP_FALL = 3'b100
  } tpcc_cap_state_t;

  typedef struct packed {
    logic [7:0] rise;
    logic [7:0] fall;
  } tpcc_cap_t;

  typedef struct packed {
    logic clk;
    logic rst;
  } tpcc_pins_t;

endpackage

// file: tpcc_pulse_src.sv
// Pulse source on the capture reset inputs of unit one and unit A.
// Assumes the bench calls pulse just after a rising clock edge.
`timescale 1ns/1ps

module tpcc_pulse_src (
  // Clock
  input wire logic clk,
  // Capture inputs toward the block
  output logic pin_x,
  output logic pin_a
);
  initial begin
    pin_x = 1'b0;
    pin_a = 1'b0;
  end

  // one high pulse of len cycles
  task automatic pulse(input logic unit_a, input int len);
    @(posedge clk);
    if (unit_a) pin_a <= 1'b1;
    else pin_x <= 1'b1;
    repeat (len) @(posedge clk);
    pin_a <= 1'b0;
    pin_x <= 1'b0;
  endtask
endmodule

// file: tpcc_sva.sv
// Checker for the pulse capture / compare block, watching top ports only.
// Assumes a bus master that holds each request until it is accepted.
`timescale 1ns/1ps

module tpcc_sva
  import tpcc_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // Register bus
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] READDATA,
  input wire logic WAITREQUEST,
  // Pins and outputs
  input wire tpcc_pins_t Y_PIN,
  input wire tpcc_pins_t B_PIN,
  input wire tpcc_pins_t Y_EXT,
  input wire tpcc_pins_t B_EXT,
  input wire logic COMPARE_MATCH_C,
  input wire logic IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  chk_wait_once: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
    else $error("request waited more than one cycle");
  chk_wait_idle: assert property (!(READ || WRITE) |-> !WAITREQUEST)
    else $error("wait asserted with no request");
  chk_rdata_upper: assert property (READ && !WAITREQUEST |-> READDATA[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  chk_rdata_hold: assert property (!$past(READ) && !$past(RESET) |-> $stable(READDATA))
    else $error("read data changed without a read");
  chk_reset_quiet: assert property (disable iff (1'b0)
      RESET |=> !IRQ && !COMPARE_MATCH_C && Y_EXT == 2'b00 && B_EXT == 2'b00)
    else $error("outputs not quiet after reset");
  chk_gate_y: assert property (1'b1 |=> Y_EXT == $past(Y_PIN) || Y_EXT == 2'b00)
    else $error("unit two pins neither gated nor passed");
  chk_gate_b: assert property (1'b1 |=> B_EXT == $past(B_PIN) || B_EXT == 2'b00)
    else $error("unit B pins neither gated nor passed");
  // The counter steps every cycle, so a match lasts one cycle unless a write moved it
  chk_match_single: assert property (COMPARE_MATCH_C && !WRITE && !$past(WRITE)
      |=> !COMPARE_MATCH_C)
    else $error("compare match held two cycles");

  cover property ($rose(COMPARE_MATCH_C));
  cover property ($rose(IRQ));
  cover property (Y_EXT != 2'b00 && B_EXT != 2'b00);
endmodule

// file: tpcc_top.sv
// Pulse-width capture, sum compare C, pin gating and register window select.
// Assumes an Avalon-MM master on CORE_CLK and pins already synchronous to it.
//
// Function
// R1 - Compare counter with constant plus capture
// R2 - Suppress compare on constant write, capture
// R3 - Sum constant register, reset all ones
// R4 - Capture registers read-only, reset zero
// R5 - Armed: capture rise, then fall
// R6 - Start bit clears after one pair
// R7 - Start bit set by read-0-then-write-1
// R8 - Start bit enables single-shot width measurement
// R9 - Gate bit blocks or passes pin
// R10 - Input select upper bits stay ones
// R11 - Window bit chooses unit one/two
// R12 - Window address map per select
// R13 - Reserved control bits reset zero, writable
// R14 - Capture flag set; read-1, write-0 clears
// R15 - Rising capture used, sum modulo 256
`timescale 1ns/1ps

module tpcc_top
  import tpcc_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // Avalon-MM slave
  input wire logic [17:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [3:0] BYTEENABLE,
  input wire logic [31:0] WRITEDATA,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // Capture reset inputs of unit one and unit A, and the unit A counter value
  input wire logic UNIT_X_RESET_INPUT,
  input wire logic UNIT_A_RESET_INPUT,
  input wire logic [7:0] UNIT_A_COUNTER,
  // Clock/reset pins of unit two and unit B
  input wire tpcc_pins_t Y_PIN,
  input wire tpcc_pins_t B_PIN,
  output tpcc_pins_t Y_EXT,
  output tpcc_pins_t B_EXT,
  // Compare and interrupt
  output logic COMPARE_MATCH_C,
  output logic IRQ
);

  localparam int UNITS = 2;

  function automatic tpcc_reg_t reg_decode(input logic [15:0] ix, input logic ysel);
    case (ix)
      `TPCC_IX_W0: reg_decode = ysel ? TPCC_R_YCTL : TPCC_R_XCTL;
      `TPCC_IX_W1: reg_decode = ysel ? TPCC_R_YST : TPCC_R_XST;
      `TPCC_IX_W2: reg_decode = ysel ? TPCC_R_YCA : TPCC_R_RISE;
      `TPCC_IX_W3: reg_decode = ysel ? TPCC_R_YCB : TPCC_R_FALL;
      `TPCC_IX_W4: reg_decode = ysel ? TPCC_R_YCNT : TPCC_R_XCNT;
      `TPCC_IX_W5: reg_decode = ysel ? TPCC_R_YISEL : TPCC_R_SUMC;
      `TPCC_IX_W6: reg_decode = ysel ? TPCC_R_NONE : TPCC_R_XCA;
      `TPCC_IX_W7: reg_decode = ysel ? TPCC_R_NONE : TPCC_R_XCB;
      `TPCC_IX_CONN: reg_decode = TPCC_R_CONN;
      `TPCC_IX_WSEL: reg_decode = TPCC_R_WSEL;
      `TPCC_IX_ABCTL: reg_decode = TPCC_R_ABCTL;
      `TPCC_IX_A_RISE: reg_decode = TPCC_R_ARISE;
      `TPCC_IX_A_FALL: reg_decode = TPCC_R_AFALL;
      `TPCC_IX_B_ISEL: reg_decode = TPCC_R_BISEL;
      `TPCC_IX_IRQ_ST: reg_decode = TPCC_R_IST;
      `TPCC_IX_IRQ_MASK: reg_decode = TPCC_R_IMSK;
      default: reg_decode = TPCC_R_NONE;
    endcase
  endfunction

  logic ack_reg;
  logic [7:0] rdata_reg;
  logic [7:0] xctl_reg, xst_reg, xcnt_reg, sumc_reg, xca_reg, xcb_reg;
  logic [7:0] yctl_reg, yst_reg, yca_reg, ycb_reg, ycnt_reg, yisel_reg;
  logic [7:0] conn_reg, wsel_reg, abctl_reg, bisel_reg;
  logic [`TPCC_EV_W-1:0] ist_reg, imsk_reg;
  logic [UNITS-1:0] arm_seen_reg;
  logic capf_seen_reg;
  logic [UNITS-1:0] rin_prev_reg;
  tpcc_cap_state_t cap_state_reg [UNITS];
  tpcc_cap_t cap_reg [UNITS];
  logic cmp_reg;
  logic y_clk_prev_reg;

  tpcc_reg_t sel;
  logic req, rd_go, wr_go, wr_lo;
  logic [7:0] wd, rd_mux, sum_c;
  logic [UNITS-1:0] rin, capture_start_bit, rise_ev, fall_ev, rise_ld, cap_done;
  logic suppress_c, equal_c;
  logic [`TPCC_EV_W-1:0] events;

  // Bus handshake: one wait cycle, answer taken on the second edge
  assign req = READ | WRITE;
  assign WAITREQUEST = req & ~ack_reg;
  assign rd_go = READ & ack_reg;
  assign wr_go = WRITE & ack_reg;
  assign wr_lo = wr_go & BYTEENABLE[0];
  assign wd = WRITEDATA[7:0];
  // R11 - window select routes
  assign sel = reg_decode(ADDRESS[17:2], wsel_reg[`TPCC_WSEL_BIT]);
  assign READDATA = {24'h000000, rdata_reg};

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // R12 - window read map
  always_comb begin
    case (sel)
      TPCC_R_XCTL: rd_mux = xctl_reg;
      TPCC_R_XST: rd_mux = xst_reg;
      TPCC_R_RISE: rd_mux = cap_reg[0].rise;
      TPCC_R_FALL: rd_mux = cap_reg[0].fall;
      TPCC_R_XCNT: rd_mux = xcnt_reg;
      TPCC_R_SUMC: rd_mux = sumc_reg;
      TPCC_R_XCA: rd_mux = xca_reg;
      TPCC_R_XCB: rd_mux = xcb_reg;
      TPCC_R_YCTL: rd_mux = yctl_reg;
      TPCC_R_YST: rd_mux = yst_reg;
      TPCC_R_YCA: rd_mux = yca_reg;
      TPCC_R_YCB: rd_mux = ycb_reg;
      TPCC_R_YCNT: rd_mux = ycnt_reg;
      TPCC_R_YISEL: rd_mux = yisel_reg;
      TPCC_R_CONN: rd_mux = conn_reg;
      TPCC_R_WSEL: rd_mux = wsel_reg;
      TPCC_R_ABCTL: rd_mux = abctl_reg;
      TPCC_R_ARISE: rd_mux = cap_reg[1].rise;
      TPCC_R_AFALL: rd_mux = cap_reg[1].fall;
      TPCC_R_BISEL: rd_mux = bisel_reg;
      TPCC_R_IST: rd_mux = {5'h00, ist_reg};
      TPCC_R_IMSK: rd_mux = {5'h00, imsk_reg};
      default: rd_mux = `TPCC_ZERO8;
    endcase
  end

  // Snapshot in the wait cycle; read side effects use this snapshot
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      rdata_reg <= `TPCC_ZERO8;
    end else if (READ & ~ack_reg) begin
      rdata_reg <= rd_mux;
    end
  end

  // Plain storage registers of both units and the interrupt mask
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      xctl_reg <= `TPCC_ZERO8;
      xca_reg <= `TPCC_SUMC_RST;
      xcb_reg <= `TPCC_SUMC_RST;
      yctl_reg <= `TPCC_ZERO8;
      yst_reg <= `TPCC_ZERO8;
      yca_reg <= `TPCC_SUMC_RST;
      ycb_reg <= `TPCC_SUMC_RST;
      imsk_reg <= '0;
    end else if (wr_lo) begin
      case (sel)
        TPCC_R_XCTL: xctl_reg <= wd;
        TPCC_R_XCA: xca_reg <= wd;
        TPCC_R_XCB: xcb_reg <= wd;
        TPCC_R_YCTL: yctl_reg <= wd;
        TPCC_R_YST: yst_reg <= wd;
        TPCC_R_YCA: yca_reg <= wd;
        TPCC_R_YCB: ycb_reg <= wd;
        TPCC_R_IMSK: imsk_reg <= wd[`TPCC_EV_W-1:0];
        default: xctl_reg <= xctl_reg;
      endcase
    end
  end

  // R3 - constant register, reset ones
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      sumc_reg <= `TPCC_SUMC_RST;
    end else if (wr_lo && sel == TPCC_R_SUMC) begin
      sumc_reg <= wd;
    end
  end

  // R13 - reserved bits writable, reset zero
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      wsel_reg <= `TPCC_ZERO8;
    end else if (wr_lo && sel == TPCC_R_WSEL) begin
      wsel_reg <= wd;
    end
  end

  // R10 - upper select bits held ones
  // R9 - only the gate bit writes
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      yisel_reg <= `TPCC_ISEL_RST;
      bisel_reg <= `TPCC_ISEL_RST;
    end else if (wr_lo) begin
      if (sel == TPCC_R_YISEL) begin
        yisel_reg[`TPCC_GATE_BIT] <= wd[`TPCC_GATE_BIT];
      end
      if (sel == TPCC_R_BISEL) begin
        bisel_reg[`TPCC_GATE_BIT] <= wd[`TPCC_GATE_BIT];
      end
    end
  end

  // R9 - pin gating of units two and B
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      Y_EXT <= '0;
      B_EXT <= '0;
    end else begin
      Y_EXT <= yisel_reg[`TPCC_GATE_BIT] ? Y_PIN : '0;
      B_EXT <= bisel_reg[`TPCC_GATE_BIT] ? B_PIN : '0;
    end
  end

  // Unit two counter steps on gated clock edges; bus write wins
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      y_clk_prev_reg <= 1'b0;
      ycnt_reg <= `TPCC_ZERO8;
    end else begin
      y_clk_prev_reg <= Y_EXT.clk;
      if (wr_lo && sel == TPCC_R_YCNT) begin
        ycnt_reg <= wd;
      end else if (Y_EXT.clk & ~y_clk_prev_reg) begin
        ycnt_reg <= ycnt_reg + `TPCC_ONE8;
      end
    end
  end

  // Unit one counter runs on every core clock; bus write wins
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      xcnt_reg <= `TPCC_ZERO8;
    end else if (wr_lo && sel == TPCC_R_XCNT) begin
      xcnt_reg <= wd;
    end else begin
      xcnt_reg <= xcnt_reg + `TPCC_ONE8;
    end
  end

  // Capture edge detection, unit one = 0, unit A = 1
  assign rin = {UNIT_A_RESET_INPUT, UNIT_X_RESET_INPUT};
  assign capture_start_bit = {abctl_reg[`TPCC_CAPTURE_START_BIT_A_BIT], conn_reg[`TPCC_CAPTURE_START_BIT_X_BIT]};
  assign rise_ev = rin & ~rin_prev_reg;
  assign fall_ev = ~rin & rin_prev_reg;

  always_comb begin
    for (int u = 0; u < UNITS; u++) begin
      rise_ld[u] = (cap_state_reg[u] == TPCC_CAP_RISE) & rise_ev[u];
      cap_done[u] = (cap_state_reg[u] == TPCC_CAP_FALL) & fall_ev[u];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      rin_prev_reg <= '0;
    end else begin
      rin_prev_reg <= rin;
    end
  end

  // R5 - rise then fall capture
  // R8 - single-shot width measurement
  // R4 - capture registers reset zero
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      for (int u = 0; u < UNITS; u++) begin
        cap_state_reg[u] <= TPCC_CAP_IDLE;
        cap_reg[u] <= '0;
      end
    end else begin
      for (int u = 0; u < UNITS; u++) begin
        case (cap_state_reg[u])
          TPCC_CAP_IDLE: begin
            if (capture_start_bit[u]) begin
              cap_state_reg[u] <= TPCC_CAP_RISE;
            end
          end
          TPCC_CAP_RISE: begin
            if (!capture_start_bit[u]) begin
              cap_state_reg[u] <= TPCC_CAP_IDLE;
            end else if (rise_ev[u]) begin
              cap_reg[u].rise <= (u == 0) ? xcnt_reg : UNIT_A_COUNTER;
              cap_state_reg[u] <= TPCC_CAP_FALL;
            end
          end
          TPCC_CAP_FALL: begin
            if (!capture_start_bit[u]) begin
              cap_state_reg[u] <= TPCC_CAP_IDLE;
            end else if (fall_ev[u]) begin
              cap_reg[u].fall <= (u == 0) ? xcnt_reg : UNIT_A_COUNTER;
              cap_state_reg[u] <= TPCC_CAP_IDLE;
            end
          end
          default: cap_state_reg[u] <= TPCC_CAP_IDLE;
        endcase
      end
    end
  end

  // R7 - remember start bit read as 0
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      arm_seen_reg <= '0;
    end else begin
      if (rd_go && sel == TPCC_R_CONN) begin
        arm_seen_reg[0] <= ~rdata_reg[`TPCC_CAPTURE_START_BIT_X_BIT];
      end else if (wr_go && sel == TPCC_R_CONN) begin
        arm_seen_reg[0] <= 1'b0;
      end
      if (rd_go && sel == TPCC_R_ABCTL) begin
        arm_seen_reg[1] <= ~rdata_reg[`TPCC_CAPTURE_START_BIT_A_BIT];
      end else if (wr_go && sel == TPCC_R_ABCTL) begin
        arm_seen_reg[1] <= 1'b0;
      end
    end
  end

  // R6 - start bit clears after pair
  // R7 - write 1 arms only after read 0
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      conn_reg <= `TPCC_ZERO8;
      abctl_reg <= `TPCC_ZERO8;
    end else begin
      if (cap_done[0]) begin
        conn_reg[`TPCC_CAPTURE_START_BIT_X_BIT] <= 1'b0;
      end
      if (cap_done[1]) begin
        abctl_reg[`TPCC_CAPTURE_START_BIT_A_BIT] <= 1'b0;
      end
      if (wr_lo && sel == TPCC_R_CONN) begin
        conn_reg <= wd;
        conn_reg[`TPCC_CAPTURE_START_BIT_X_BIT] <= wd[`TPCC_CAPTURE_START_BIT_X_BIT] &
          (conn_reg[`TPCC_CAPTURE_START_BIT_X_BIT] | arm_seen_reg[0]) & ~cap_done[0];
      end
      if (wr_lo && sel == TPCC_R_ABCTL) begin
        abctl_reg <= wd;
        abctl_reg[`TPCC_CAPTURE_START_BIT_A_BIT] <= wd[`TPCC_CAPTURE_START_BIT_A_BIT] &
          (abctl_reg[`TPCC_CAPTURE_START_BIT_A_BIT] | arm_seen_reg[1]) & ~cap_done[1];
      end
    end
  end

  // R14 - capture flag, read-1 then write-0 clears
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      capf_seen_reg <= 1'b0;
    end else if (rd_go && sel == TPCC_R_XST) begin
      capf_seen_reg <= rdata_reg[`TPCC_CAPF_BIT];
    end else if (wr_go && sel == TPCC_R_XST) begin
      capf_seen_reg <= 1'b0;
    end
  end

  // R14 - set wins over clear
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      xst_reg <= `TPCC_ZERO8;
    end else begin
      if (wr_lo && sel == TPCC_R_XST) begin
        xst_reg <= wd & `TPCC_XST_RW_MASK;
        xst_reg[`TPCC_CAPF_BIT] <= cap_done[0] | (xst_reg[`TPCC_CAPF_BIT] &
          (wd[`TPCC_CAPF_BIT] | ~capf_seen_reg));
      end else if (cap_done[0]) begin
        xst_reg[`TPCC_CAPF_BIT] <= 1'b1;
      end
    end
  end

  // R15 - rising capture, sum modulo 256
  assign sum_c = 8'(sumc_reg + cap_reg[0].rise);
  // R2 - suppress on constant write, capture load
  assign suppress_c = (wr_go && sel == TPCC_R_SUMC) | rise_ld[0] | cap_done[0];
  // R1 - continuous compare with constant sum
  assign equal_c = (xcnt_reg == sum_c) & ~suppress_c;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      cmp_reg <= 1'b0;
    end else begin
      cmp_reg <= equal_c;
    end
  end

  assign COMPARE_MATCH_C = cmp_reg;

  // Interrupt status: read clears only bits the snapshot showed
  assign events = {equal_c, cap_done[1], cap_done[0]};

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ist_reg <= '0;
    end else if (rd_go && sel == TPCC_R_IST) begin
      ist_reg <= (ist_reg & ~rdata_reg[`TPCC_EV_W-1:0]) | events;
    end else begin
      ist_reg <= ist_reg | events;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |((ist_reg | events) & imsk_reg);
    end
  end

endmodule
